// [design/shift_datapath.sv]
// Single-cycle rotate, mask and three-input ALU shift datapath
`timescale 1ns/1ns
//////////////////////////////////////////////////////////////////////////////
// What this block does
// - Rotator turns the input left by the amount, wrapping, into port B.
// - Mask takes the same amount and gives that many low ones (all ones at zero with shr_mod) on port C, except classes 0 and 6 that route a source.
// - A plain left shift computes B AND NOT C to strip wrapped bits.
// - The amount is a 5-bit immediate, a register's low five bits or zero.
// - Shift left and add gives A plus (B AND NOT C) with the same amount.
// - Every shift form, alone or with add or subtract, takes one cycle.
// - No overflow indication is raised for a left shift.
// - A 3-bit operation class picks one of five source routings.
// - Amount mux: register, extended op reg, immediate or zero; 5 bits.
module shift_datapath #(
    parameter int unsigned DATA_W = shift_dp_pkg::DATA_W
) (
    input  wire logic                  ref_clk,  // Core clock
    input  wire logic                  rst,      // Sync reset, high
    input  wire logic                  req_valid, // Operation present
    input  wire shift_dp_pkg::dp_req_t req,      // Operands and controls
    output shift_dp_pkg::dp_rsp_t      rsp_q,    // Registered result
    output logic                       rsp_valid_q // Result valid
);
    // Only the documented word width is served
    if (DATA_W != shift_dp_pkg::DATA_W) begin : g_bad_width
        $error("shift_datapath: DATA_W must be 32");
    end

    //////////////////////////////////////////////////////////////////////////
    // Source routing per operation class
    logic [31:0] rot_in;
    logic [31:0] a_port;
    logic [31:0] amt_reg_src;
    logic        c_from_mask;
    logic [31:0] c_direct;

    always_comb begin
        rot_in      = req.first_source;
        a_port      = req.second_source;
        amt_reg_src = req.second_source;
        c_from_mask = 1'b1;
        c_direct    = req.second_source;
        case (req.op_class)
            3'h0: begin
                c_from_mask = 1'b0;
                c_direct    = req.third_source;
            end
            3'h1, 3'h3, 3'h4: begin
                a_port = req.second_source;
            end
            3'h2, 3'h5: begin
                a_port      = req.third_source;
                amt_reg_src = req.second_source;
            end
            3'h6: begin
                c_from_mask = 1'b0;
            end
            3'h7: begin
                a_port      = req.first_source;
                rot_in      = req.second_source;
                amt_reg_src = req.third_source;
            end
            default: begin
                a_port = req.second_source;
            end
        endcase
    end

    //////////////////////////////////////////////////////////////////////////
    // Rotate amount multiplexer
    logic [4:0] amt;

    always_comb begin
        case (req.amt_sel)
            shift_dp_pkg::AMT_REG:  amt = amt_reg_src[4:0];
            shift_dp_pkg::AMT_EXT:  amt = req.extended_op_reg[4:0];
            shift_dp_pkg::AMT_IMM:  amt = req.imm_amt;
            shift_dp_pkg::AMT_ZERO: amt = 5'h00;
            default:                amt = 5'h00;
        endcase
    end

    //////////////////////////////////////////////////////////////////////////
    // Rotator and mask
    logic [31:0] b_port;
    logic [31:0] mask;
    logic [31:0] c_port;

    always_comb begin
        b_port = (rot_in << amt) | (rot_in >> (6'd32 - {1'b0, amt}));
    end

    mask_gen #(
        .WIDTH (32),
        .AMT   (5)
    ) u_mask (
        .amount    (amt),
        .full_on_0 (req.shr_mod),
        .mask      (mask)
    );

    assign c_port = c_from_mask ? mask : c_direct;

    //////////////////////////////////////////////////////////////////////////
    // Three-input ALU
    logic [31:0] opnd;
    logic        sub;
    logic        arith;
    logic [32:0] sum;
    logic [31:0] res;
    logic        carry;
    logic        ovf;

    // all shift forms in one pass
    always_comb begin
        opnd  = b_port & ~c_port;
        sub   = 1'b0;
        arith = 1'b0;
        case (req.func)
            shift_dp_pkg::FN_SHL: opnd = b_port & ~c_port;
            shift_dp_pkg::FN_SHL_ADD: begin
                arith = 1'b1;
            end
            shift_dp_pkg::FN_SHL_SUB: begin
                arith = 1'b1;
                sub   = 1'b1;
            end
            shift_dp_pkg::FN_SHR: opnd = b_port & c_port;
            shift_dp_pkg::FN_SHR_ADD: begin
                opnd  = b_port & c_port;
                arith = 1'b1;
            end
            shift_dp_pkg::FN_SHR_SUB: begin
                opnd  = b_port & c_port;
                arith = 1'b1;
                sub   = 1'b1;
            end
            shift_dp_pkg::FN_ASR:
                opnd = (b_port & c_port) | ({32{rot_in[31]}} & ~c_port);
            shift_dp_pkg::FN_ADD: begin
                opnd  = b_port;
                arith = 1'b1;
            end
            default: opnd = b_port & ~c_port;
        endcase
        if (arith) begin
            sum = {1'b0, a_port} + {1'b0, sub ? ~opnd : opnd}
                + {32'h0000_0000, sub};
        end else begin
            sum = {1'b0, opnd};
        end
        res   = sum[31:0];
        // overflow only from add or subtract
        carry = arith & sum[32];
        ovf   = arith & (a_port[31] == (sub ? ~opnd[31] : opnd[31]))
              & (res[31] != a_port[31]);
    end

    //////////////////////////////////////////////////////////////////////////
    // Result register
    // status for every class
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            rsp_q.value <= shift_dp_pkg::RESULT_RST;
            rsp_q.flags <= shift_dp_pkg::FLAGS_RST;
        end else if (req_valid) begin
            rsp_q.value <= res;
            rsp_q.flags[shift_dp_pkg::FLAG_C] <= carry;
            rsp_q.flags[shift_dp_pkg::FLAG_N] <= res[31];
            rsp_q.flags[shift_dp_pkg::FLAG_V] <= ovf;
            rsp_q.flags[shift_dp_pkg::FLAG_Z] <= (res == 32'h0000_0000);
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            rsp_valid_q <= 1'b0;
        end else begin
            rsp_valid_q <= req_valid;
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // Checks
    a_shl_result: assert property (@(posedge ref_clk)
        disable iff (rst)
        req_valid && req.func == shift_dp_pkg::FN_SHL && c_from_mask
        && !(req.shr_mod && amt == 5'h00)
        |=> rsp_q.value == (($past(rot_in) << $past(amt)) & 32'hFFFF_FFFF))
        else $error("shift left result wrong");

    a_shl_add: assert property (@(posedge ref_clk) disable iff (rst)
        req_valid && req.func == shift_dp_pkg::FN_SHL_ADD && c_from_mask
        && !(req.shr_mod && amt == 5'h00)
        |=> rsp_q.value == $past(a_port) + ($past(rot_in) << $past(amt)))
        else $error("shift left add result wrong");

    a_rot_wrap: assert property (@(posedge ref_clk) disable iff (rst)
        amt == 5'h01 |-> b_port == {rot_in[30:0], rot_in[31]})
        else $error("rotate by one wrong");

    a_mask_count: assert property (@(posedge ref_clk)
        disable iff (rst)
        !req.shr_mod |-> $countones(mask) == amt && mask[0] == (amt != 5'h00))
        else $error("mask ones count wrong");

    a_mask_full: assert property (@(posedge ref_clk) disable iff (rst)
        req.shr_mod && amt == 5'h00 |-> mask == 32'hFFFF_FFFF)
        else $error("full mask on zero amount missing");

    a_amt_imm: assert property (@(posedge ref_clk) disable iff (rst)
        req.amt_sel == shift_dp_pkg::AMT_IMM |-> amt == req.imm_amt)
        else $error("immediate amount not used");

    a_amt_sources: assert property (@(posedge ref_clk)
        disable iff (rst)
        (req.amt_sel == shift_dp_pkg::AMT_ZERO |-> amt == 5'h00) and
        (req.amt_sel == shift_dp_pkg::AMT_EXT
            |-> amt == req.extended_op_reg[4:0]))
        else $error("amount multiplexer wrong");

    a_one_cycle: assert property (@(posedge ref_clk) disable iff (rst)
        req_valid |=> rsp_valid_q ##1 (rsp_valid_q == $past(req_valid)))
        else $error("result not in one cycle");

    a_no_shl_ovf: assert property (@(posedge ref_clk)
        disable iff (rst)
        req_valid && req.func == shift_dp_pkg::FN_SHL
        |=> !rsp_q.flags[shift_dp_pkg::FLAG_V])
        else $error("overflow raised on shift left");

    a_zero_flag: assert property (@(posedge ref_clk) disable iff (rst)
        rsp_valid_q |-> rsp_q.flags[shift_dp_pkg::FLAG_Z]
            == (rsp_q.value == 32'h0000_0000)
            && rsp_q.flags[shift_dp_pkg::FLAG_N] == rsp_q.value[31])
        else $error("status flags wrong");

    a_class_route: assert property (@(posedge ref_clk)
        disable iff (rst)
        req.op_class == 3'h7 |-> a_port == req.first_source
            && rot_in == req.second_source)
        else $error("class routing wrong");
endmodule

// [inc/shift_dp_pkg.sv]
// Package of constants and carriers for the rotate/mask/shift datapath
package shift_dp_pkg;
    localparam int unsigned DATA_W    = 32;
    localparam int unsigned AMT_W     = 5;
    localparam int unsigned CLASS_W   = 3;
    localparam int unsigned FUNC_W    = 3;
    localparam logic [31:0] RESULT_RST = 32'h0000_0000;

    // Flag bit positions in the status word
    localparam int unsigned FLAG_C = 3;
    localparam int unsigned FLAG_N = 2;
    localparam int unsigned FLAG_V = 1;
    localparam int unsigned FLAG_Z = 0;
    localparam logic [3:0]  FLAGS_RST = 4'h0;

    // ALU functions
    localparam logic [2:0] FN_SHL     = 3'h0; // B & ~C
    localparam logic [2:0] FN_SHL_ADD = 3'h1; // A + (B & ~C)
    localparam logic [2:0] FN_SHL_SUB = 3'h2; // A - (B & ~C)
    localparam logic [2:0] FN_SHR     = 3'h3; // B & C
    localparam logic [2:0] FN_SHR_ADD = 3'h4; // A + (B & C)
    localparam logic [2:0] FN_SHR_SUB = 3'h5; // A - (B & C)
    localparam logic [2:0] FN_ASR     = 3'h6; // B & C | sign & ~C
    localparam logic [2:0] FN_ADD     = 3'h7; // A + B

    // Rotate amount sources
    localparam logic [1:0] AMT_REG  = 2'h0;
    localparam logic [1:0] AMT_EXT  = 2'h1;
    localparam logic [1:0] AMT_IMM  = 2'h2;
    localparam logic [1:0] AMT_ZERO = 2'h3;

    typedef struct packed {
        logic [2:0]  op_class;     // Multiplexer configuration
        logic [2:0]  func;         // ALU function
        logic [1:0]  amt_sel;      // Rotate amount source
        logic        shr_mod;      // Zero amount gives full mask
        logic [4:0]  imm_amt;      // Immediate shift amount
        logic [31:0] first_source;
        logic [31:0] second_source;
        logic [31:0] third_source;
        logic [31:0] extended_op_reg;
    } dp_req_t;

    typedef struct packed {
        logic [31:0] value;
        logic [3:0]  flags;        // C N V Z
    } dp_rsp_t;
endpackage

// [design/mask_gen.sv]
// Right-justified mask generator
`timescale 1ns/1ns
module mask_gen #(
    parameter int unsigned WIDTH = 32,
    parameter int unsigned AMT   = 5
) (
    input  wire logic [AMT-1:0]   amount,   // Count of ones
    input  wire logic             full_on_0, // Zero gives all ones
    output logic      [WIDTH-1:0] mask      // Mask output
);
    // The amount must span the word exactly
    if (WIDTH != (1 << AMT)) begin : g_bad_size
        $error("mask_gen: WIDTH must equal 2**AMT");
    end

    always_comb begin
        mask = ~({WIDTH{1'b1}} << amount);
        if (full_on_0 && amount == '0) begin
            mask = {WIDTH{1'b1}};
        end
    end
endmodule

// [sim/result_sink.sv]
// Register file write-back model that collects datapath results
`timescale 1ns/1ns
module result_sink (
    input  wire logic                  ref_clk,     // Core clock
    input  wire logic                  rst,         // Sync reset, high
    input  wire logic                  rsp_valid_q, // Result present
    input  wire shift_dp_pkg::dp_rsp_t rsp_q,       // Result word
    output logic [31:0]                wb_value,    // Last written value
    output int                         wb_count     // Results written
);
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            wb_count <= 0;
        end else if (rsp_valid_q) begin
            wb_count <= wb_count + 1;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            wb_value <= 32'h0000_0000;
        end else if (rsp_valid_q) begin
            wb_value <= rsp_q.value;
        end
    end
endmodule

// [sim/rotate_mask_shift_datapath_test.sv]
// Self-checking bench for the shift datapath
`timescale 1ns/1ns
module rotate_mask_shift_datapath_test;
    logic                  ref_clk;
    logic                  rst;
    logic                  req_valid;
    logic                  rsp_valid_q;
    logic                  prv_v;
    logic [31:0]           wb_value;
    shift_dp_pkg::dp_req_t req;
    shift_dp_pkg::dp_req_t r;
    shift_dp_pkg::dp_rsp_t rsp_q;
    shift_dp_pkg::dp_rsp_t prv_e;
    int                    wb_count;
    int                    sent;
    int                    err_total;
    int                    tests_run;
    int                    seed;

    shift_datapath dut_u (.ref_clk(ref_clk), .rst(rst),
        .req_valid(req_valid), .req(req), .rsp_q(rsp_q),
        .rsp_valid_q(rsp_valid_q));
    result_sink sink_u (.ref_clk(ref_clk), .rst(rst),
        .rsp_valid_q(rsp_valid_q), .rsp_q(rsp_q), .wb_value(wb_value),
        .wb_count(wb_count));

    //////////////////////////////////////////////////////////////////////
    // Expected result from the class routing and the ALU function
    function automatic shift_dp_pkg::dp_rsp_t expect_rsp(
        input shift_dp_pkg::dp_req_t q);
        logic [4:0]            n;
        logic [31:0]           rot;
        logic [31:0]           a;
        logic [31:0]           sreg;
        logic [63:0]           w;
        logic [31:0]           b;
        logic [31:0]           c;
        logic [31:0]           x;
        logic                  sb;
        logic                  ar;
        logic [32:0]           s;
        shift_dp_pkg::dp_rsp_t o;
        rot  = q.first_source;
        a    = q.second_source;
        sreg = q.second_source;
        if (q.op_class == 3'h2 || q.op_class == 3'h5) begin
            a = q.third_source;
        end
        if (q.op_class == 3'h7) begin
            rot  = q.second_source;
            a    = q.first_source;
            sreg = q.third_source;
        end
        case (q.amt_sel)
            shift_dp_pkg::AMT_REG: n = sreg[4:0];
            shift_dp_pkg::AMT_EXT: n = q.extended_op_reg[4:0];
            shift_dp_pkg::AMT_IMM: n = q.imm_amt;
            default:               n = 5'h00;
        endcase
        w = {rot, rot} << n;
        b = w[63:32];
        c = ~(32'hFFFF_FFFF << n);
        if (q.shr_mod && n == 5'h00) begin
            c = 32'hFFFF_FFFF;
        end
        if (q.op_class == 3'h0) begin
            c = q.third_source;
        end
        if (q.op_class == 3'h6) begin
            c = q.second_source;
        end
        sb = q.func == shift_dp_pkg::FN_SHL_SUB
            || q.func == shift_dp_pkg::FN_SHR_SUB;
        ar = sb || q.func == shift_dp_pkg::FN_SHL_ADD
            || q.func == shift_dp_pkg::FN_SHR_ADD
            || q.func == shift_dp_pkg::FN_ADD;
        case (q.func)
            shift_dp_pkg::FN_SHL, shift_dp_pkg::FN_SHL_ADD,
            shift_dp_pkg::FN_SHL_SUB: x = b & ~c;
            shift_dp_pkg::FN_ASR:     x = (b & c) | ({32{rot[31]}} & ~c);
            shift_dp_pkg::FN_ADD:     x = b;
            default:                  x = b & c;
        endcase
        if (sb) begin
            x = ~x;
        end
        s = {1'b0, x};
        if (ar) begin
            s = {1'b0, a} + {1'b0, x} + {32'h0000_0000, sb};
        end
        o.value = s[31:0];
        o.flags = 4'h0;
        o.flags[shift_dp_pkg::FLAG_C] = ar & s[32];
        o.flags[shift_dp_pkg::FLAG_V] = ar && (a[31] == x[31])
            && (s[31] != a[31]);
        o.flags[shift_dp_pkg::FLAG_N] = o.value[31];
        o.flags[shift_dp_pkg::FLAG_Z] = (o.value == 32'h0000_0000);
        return o;
    endfunction

    function automatic logic ovf_shl(input logic [31:0] b,
                                     input logic [4:0] n);
        return ($signed(b << n) >>> n) != $signed(b);
    endfunction

    task automatic cmp(input logic [35:0] got, input logic [35:0] exp);
        tests_run++;
        if (got !== exp) begin
            err_total++;
            $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
        end
    endtask

    // One cycle: drive a request, check the answer to the one before
    task automatic step(input logic v, input shift_dp_pkg::dp_req_t q);
        @(posedge ref_clk);
        req       <= q;
        req_valid <= v;
        @(negedge ref_clk);
        cmp({35'h0, rsp_valid_q}, {35'h0, prv_v});
        cmp(rsp_q, prv_e);
        prv_v = v;
        sent += v;
        if (v) begin
            prv_e = expect_rsp(q);
        end
    endtask

    task automatic rnd(input logic [2:0] cls, input logic [2:0] fn,
                       input logic [1:0] sel);
        r                 = '0;
        r.op_class        = cls;
        r.func            = fn;
        r.amt_sel         = sel;
        r.imm_amt         = $random(seed);
        r.first_source    = $random(seed);
        r.second_source   = $random(seed);
        r.third_source    = $random(seed);
        r.extended_op_reg = $random(seed);
    endtask

    task automatic close_out;
        $display("Comparisons %0d, mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    //////////////////////////////////////////////////////////////////////
    initial begin
        ref_clk = 1'b0;
        forever #10 ref_clk = ~ref_clk;
    end

    initial begin
        repeat (20000) @(posedge ref_clk);
        err_total++;
        $display("MISMATCH t=%0t run did not finish in time", $time);
        close_out();
    end

    initial begin
        seed = 92212;
        rst = 1'b1;
        req_valid = 1'b0;
        req = '0;
        prv_v = 1'b0;
        prv_e = '0;
        sent = 0;
        err_total = 0;
        tests_run = 0;
        repeat (8) @(posedge ref_clk);
        rst <= 1'b0;
        r = '0;
        r.op_class = 3'h1;
        r.amt_sel = shift_dp_pkg::AMT_IMM;
        r.imm_amt = 5'h04;
        r.first_source = 32'h53FF_FFA7;
        r.second_source = 32'h0000_00AA;
        step(1'b1, r);
        cmp({35'h0, ovf_shl(r.first_source, 5'h04)}, 36'h1);
        r.func = shift_dp_pkg::FN_SHL_ADD;
        step(1'b1, r);
        cmp(rsp_q.value, 32'h3FFF_FA70);
        cmp(rsp_q.flags[shift_dp_pkg::FLAG_V], 1'b0);
        r.func = shift_dp_pkg::FN_SHL_SUB;
        step(1'b1, r);
        cmp(rsp_q.value, 32'h3FFF_FB1A);
        step(1'b0, r);
        cmp(rsp_q.value, 32'hC000_063A);
        r.func = shift_dp_pkg::FN_SHR;
        r.imm_amt = 5'h1C;
        r.shr_mod = 1'b1;
        r.first_source = 32'h5CFF_FFA7;
        step(1'b1, r);
        step(1'b0, r);
        cmp(rsp_q.value, 32'h05CF_FFFA);
        $display("Test worked example done");
        for (int k = 0; k < 8; k++) begin
            rnd(3'h1, shift_dp_pkg::FN_SHL, shift_dp_pkg::AMT_IMM);
            r.imm_amt = k[0] ? 5'h1F : 5'h00;
            r.first_source = k[1] ? 32'h8000_0001 : 32'hFFFF_FFFF;
            r.shr_mod = k[2];
            step(1'b1, r);
        end
        $display("Test amount corners done");
        for (int f = 0; f < 3; f++) begin
            for (int s = 0; s < 4; s++) begin
                rnd(3'h1, f[2:0], s[1:0]);
                step(1'b1, r);
                rnd(3'h3, f[2:0], s[1:0]);
                step(1'b1, r);
                rnd(3'h4, f[2:0], s[1:0]);
                step(1'b1, r);
            end
        end
        $display("Test function and source sweep done");
        for (int i = 0; i < 400; i++) begin
            rnd(3'($random(seed)), 3'($random(seed)), 2'($random(seed)));
            r.shr_mod = 1'($random(seed));
            step($random(seed), r);
        end
        step(1'b0, r);
        step(1'b0, r);
        cmp(wb_count, sent);
        cmp(wb_value, prv_e.value);
        $display("Test random traffic done");
        close_out();
    end
endmodule
